// ==== cst_host.sv ====
// random register-access host on the backplane side
`timescale 1ns/10ps
module cst_host (
  input wire logic core_clk,
  output logic bus_sel,
  output logic bus_write,
  output logic [1:0] bus_subsys,
  output logic [2:0] bus_reg
);
  int seed = 32'h9370;
  initial begin
    {bus_sel, bus_write, bus_subsys, bus_reg} = 7'h0;
    forever begin
      @(posedge core_clk);
      #1;
      // any data: a status slot write means initialize
      {bus_sel, bus_write, bus_subsys, bus_reg} = 7'($random(seed));
    end
  end
endmodule : cst_host

// ==== cst_pkg.sv ====
// constants and types shared by the coupler self-test block
package cst_pkg;
  localparam int NUM_SUBSYS = 4;
  localparam int NUM_REGS = 8;
  localparam int REG_AW = 3;
  localparam int SUB_AW = 2;
  localparam int DATA_W = 16;
  // register index within one subsystem set
  localparam logic [2:0] BUS_BASE_ADDRESS_REG = 3'h0;
  localparam logic [2:0] BUS_DATA_BUFFER_REG = 3'h1;
  localparam logic [2:0] SUBSYSTEM_STATUS_REG = 3'h2;
  localparam logic [2:0] RESIDUAL_FRAME_COUNT_REG = 3'h3;
  localparam logic [2:0] EXTENDED_STATUS_0 = 3'h4;
  localparam logic [2:0] EXTENDED_STATUS_1 = 3'h5;
  localparam logic [2:0] EXTENDED_STATUS_2 = 3'h6;
  localparam logic [2:0] EXTENDED_STATUS_3 = 3'h7;
  // self-test duration, well under a fraction of a second
  localparam int SELFTEST_TIME_US = 100;
  localparam int CLK_MHZ = 200;
  localparam int SELFTEST_CYCLES = SELFTEST_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam logic [2:0] SYNC_INIT = 3'h0;
  localparam logic LED_AT_RESET = 1'b1;
  localparam logic [3:0] SUBSYS_HELD = 4'hf;
  typedef enum logic [1:0] {
    CST_POWERUP,
    CST_TESTING,
    CST_PASSED,
    CST_FAILED
  } cst_state_e;
endpackage : cst_pkg

// ==== cst_selftest.sv ====
// power-up self-test, fault/activity indicator and four subsystem init domains
//
// What this block does
// RULE1: self-test runs automatically on board reset switch or system power-up.
// RULE2: ordinary bus initialize never starts the self-test.
// RULE3: fault/activity indicator is lit throughout the self-test.
// RULE4: successful self-test turns the indicator off.
// RULE5: failed test keeps indicator lit and all registers unreachable.
// RULE6: four independent subsystem emulations, each with own registers and buffers.
// RULE7: initializing one subsystem leaves the other three untouched.
// RULE8: each subsystem offers eight device registers.
// RULE9: any write to a status register means subsystem initialize.
// RULE10: subsystem initialize resets that transport and coupler logic unconditionally.
// RULE11: outside self-test the indicator also lights during data transfers.
// RULE12: subsystems held in reset and accesses ignored until test passes.
`timescale 1ns/10ps
module cst_selftest #(
  parameter int SELFTEST_LEN = cst_pkg::SELFTEST_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic board_reset_switch,
  input wire logic bus_init,
  input wire logic test_fail,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [cst_pkg::SUB_AW-1:0] bus_subsys,
  input wire logic [cst_pkg::REG_AW-1:0] bus_reg,
  input wire logic [cst_pkg::NUM_SUBSYS-1:0] xfer_active,
  output logic fault_led,
  output logic selftest_done,
  output logic selftest_failed,
  output logic bus_ack,
  output logic [cst_pkg::NUM_SUBSYS-1:0] subsys_reset,
  output logic [cst_pkg::NUM_SUBSYS-1:0] subsys_access,
  output logic [cst_pkg::REG_AW-1:0] subsys_reg,
  output logic subsys_write
);
  import cst_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // switch synchroniser: three stages, change accepted when last two agree
  // a bounce shorter than two clocks never reaches sw_level, so no false restart
  logic [2:0] sw_sync;
  logic sw_level;
  logic sw_prev;
  logic next_sw_level;

  // failure flag comes from another domain, so it is filtered the same way
  logic [2:0] tf_sync;
  logic tf_level;
  logic next_tf_level;

  always_comb begin
    next_sw_level = sw_level;
    if (sw_sync[2] == sw_sync[1]) begin
      next_sw_level = sw_sync[2];
    end
    next_tf_level = tf_level;
    if (tf_sync[2] == tf_sync[1]) begin
      next_tf_level = tf_sync[2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_sync <= SYNC_INIT;
      sw_level <= 1'b0;
      sw_prev <= 1'b0;
      tf_sync <= SYNC_INIT;
      tf_level <= 1'b0;
    end else begin
      sw_sync <= {sw_sync[1:0], board_reset_switch};
      sw_level <= next_sw_level;
      sw_prev <= sw_level;
      tf_sync <= {tf_sync[1:0], test_fail};
      tf_level <= next_tf_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-test sequencer; bus_init is deliberately not an input to it
  // the counter fixes the test length; the check logic reports through test_fail
  cst_state_e state;
  cst_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic seen_fail;
  logic next_seen_fail;
  logic sw_rise;

  // edge only: a switch left on must not restart the test again and again
  assign sw_rise = sw_level && !sw_prev;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_seen_fail = seen_fail;
    unique case (state)
      CST_POWERUP: begin
        next_state = CST_TESTING; // [RULE1]
        next_cnt = '0;
        next_seen_fail = 1'b0;
      end
      CST_TESTING: begin
        next_cnt = cnt + 1'b1;
        // one failing cycle anywhere in the test is enough to fail it
        if (tf_level) begin
          next_seen_fail = 1'b1;
        end
        if (cnt >= CNT_W'(SELFTEST_LEN - 1)) begin
          next_state = (seen_fail || tf_level) ? CST_FAILED : CST_PASSED;
        end
      end
      CST_PASSED, CST_FAILED: begin
        // only the switch or a power-up reset restarts the test, never a bus initialize
        if (sw_rise) begin
          next_state = CST_POWERUP; // [RULE1] [RULE2]
        end
      end
    endcase
  end

  // power-up reset parks in CST_POWERUP, which starts the test on the first edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= CST_POWERUP;
      cnt <= '0;
      seen_fail <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      seen_fail <= next_seen_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register access gating and per-subsystem initialize
  logic next_fault_led;
  logic next_bus_ack;
  logic next_subsys_write;
  logic [REG_AW-1:0] next_subsys_reg;
  logic [NUM_SUBSYS-1:0] next_subsys_reset;
  logic [NUM_SUBSYS-1:0] next_subsys_access;
  logic next_selftest_done;
  logic next_selftest_failed;
  logic passed;

  // refuse the cycle a switch rise is seen, so no answer races the restart
  assign passed = (next_state == CST_PASSED) && (state == CST_PASSED);

  // failure holds the indicator steady; transfers cannot make it blink
  always_comb begin
    next_fault_led = 1'b0;
    next_selftest_done = (state == CST_PASSED); // [RULE4]
    next_selftest_failed = (state == CST_FAILED); // [RULE5]
    unique case (state)
      CST_POWERUP, CST_TESTING: next_fault_led = 1'b1; // [RULE3]
      CST_FAILED: next_fault_led = 1'b1; // [RULE5]
      CST_PASSED: next_fault_led = |xfer_active; // [RULE4] [RULE11]
    endcase
  end

  // failed or untested board leaves every access unanswered
  always_comb begin
    next_bus_ack = bus_sel && passed; // [RULE5] [RULE12]
    // index and direction follow the bus ungated; only access, ack and init are gated
    next_subsys_write = bus_write;
    next_subsys_reg = bus_reg; // [RULE8]
  end

  generate
    for (genvar i = 0; i < NUM_SUBSYS; i++) begin : g_sub
      // the decode is per set, so one write can never reach a neighbour
      logic hit;
      assign hit = bus_sel && passed && (bus_subsys == SUB_AW'(i));
      always_comb begin
        next_subsys_access[i] = hit; // [RULE6]
        // any data value on a status register write initializes only this set
        next_subsys_reset[i] = !passed ||
          (hit && bus_write && (bus_reg == SUBSYSTEM_STATUS_REG)); // [RULE7] [RULE9] [RULE10] [RULE12]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // indicator and verdict flops: every port comes straight from a flop, so pins never glitch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_led <= LED_AT_RESET; // [RULE3]
      selftest_done <= 1'b0;
      selftest_failed <= 1'b0;
    end else begin
      fault_led <= next_fault_led;
      selftest_done <= next_selftest_done;
      selftest_failed <= next_selftest_failed;
    end
  end

  // subsystems stay in reset from power-up until the test has passed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      subsys_reset <= SUBSYS_HELD; // [RULE12]
      subsys_access <= '0;
      subsys_reg <= '0;
      subsys_write <= 1'b0;
    end else begin
      bus_ack <= next_bus_ack;
      subsys_reset <= next_subsys_reset;
      subsys_access <= next_subsys_access;
      subsys_reg <= next_subsys_reg;
      subsys_write <= next_subsys_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus_init intentionally unused: it must not trigger the self-test
  logic unused_init;
  assign unused_init = bus_init;
endmodule : cst_selftest

// ==== cst_selftest_props.sv ====
// assertions on the coupler self-test block ports
`timescale 1ns/10ps
module cst_selftest_props #(
  parameter int SELFTEST_LEN = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [cst_pkg::SUB_AW-1:0] bus_subsys,
  input wire logic [cst_pkg::REG_AW-1:0] bus_reg,
  input wire logic [cst_pkg::NUM_SUBSYS-1:0] xfer_active,
  input wire logic fault_led,
  input wire logic selftest_done,
  input wire logic selftest_failed,
  input wire logic bus_ack,
  input wire logic [cst_pkg::NUM_SUBSYS-1:0] subsys_reset
);
  import cst_pkg::*;
  // slack covers the CST_POWERUP cycle and the verdict output flop
  localparam int T_MAX = SELFTEST_LEN + 8;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_led_in_test: assert property (!selftest_done |-> fault_led) else $error("led dark");
  a_failed_locked: assert property (selftest_failed |-> fault_led && !bus_ack) else $error("fail open");
  a_hold_until_pass: assert property (!selftest_done |-> subsys_reset == 4'hf) else $error("not held");
  a_ack_on_sel: assert property (bus_sel && selftest_done ##1 selftest_done ##1 selftest_done |->
    $past(bus_ack)) else $error("no ack");
  a_ack_cause: assert property (bus_ack |-> $past(bus_sel) && selftest_done) else $error("stray ack");
  a_init_one_only: assert property (selftest_done && $past(selftest_done) |-> $past(subsys_reset) ==
    ($past(bus_sel && bus_write && bus_reg == SUBSYSTEM_STATUS_REG, 2) ? 4'h1 << $past(bus_subsys, 2) : 4'h0))
    else $error("bad init");
  a_led_activity: assert property (selftest_done |-> fault_led == $past(|xfer_active))
    else $error("led");
  a_test_bounded: assert property (!selftest_done && !selftest_failed |->
    ##[1:T_MAX] (selftest_done || selftest_failed)) else $error("test hung");
endmodule : cst_selftest_props
bind cst_selftest cst_selftest_props #(.SELFTEST_LEN(SELFTEST_LEN)) i_props (.core_clk, .rst, .bus_sel, .bus_write,
  .bus_subsys, .bus_reg, .xfer_active, .fault_led, .selftest_done, .selftest_failed, .bus_ack, .subsys_reset);

// ==== tb.sv ====
// bench for the coupler self-test block
`timescale 1ns/10ps
module tb;
  import cst_pkg::*;
  logic core_clk = 0, rst = 1, sw = 0, bus_init = 0, tf = 0, sel, wr, led, done, failed, ack, swr;
  logic [1:0] sub;
  logic [2:0] rg, srg;
  logic [3:0] xa = 0, sr, sa;
  int n_errors = 0, compares = 0, seed = 32'h9370;
  always #2.5 core_clk = ~core_clk;
  cst_host i_cst_host (.core_clk, .bus_sel(sel), .bus_write(wr), .bus_subsys(sub), .bus_reg(rg));
  cst_selftest #(.SELFTEST_LEN(16)) i_cst_selftest (.core_clk, .rst, .board_reset_switch(sw), .bus_init,
    .test_fail(tf), .bus_sel(sel), .bus_write(wr), .bus_subsys(sub), .bus_reg(rg), .xfer_active(xa),
    .fault_led(led), .selftest_done(done), .selftest_failed(failed), .bus_ack(ack), .subsys_reset(sr),
    .subsys_access(sa), .subsys_reg(srg), .subsys_write(swr));
  task automatic chk(input logic [3:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [3:0] one(input logic s, input logic [1:0] u);
    return s ? 4'h1 << u : 4'h0;
  endfunction : one
  task automatic wait_end(input logic f);
    int n = 0;
    // the switch is synchronised, so pass drops a few cycles late
    for (int i = 0; i < 9 && done; i++) begin
      @(posedge core_clk);
      #1;
    end
    for (int i = 0; i < 40 && !done && !failed; i++) begin
      chk(led, 1);
      chk(ack, 0);
      n++;
      @(posedge core_clk);
      #1;
    end
    chk(n > 0, 1);
    chk(failed, f);
    chk(done, !f);
  endtask : wait_end
  task automatic traffic(input int n);
    logic s, w;
    logic [2:0] r;
    logic [1:0] u;
    logic [3:0] x;
    repeat (n) begin
      @(posedge core_clk);
      {s, w, r, u, x} = {sel, wr, rg, sub, xa};
      #1;
      {bus_init, xa} = 5'($random(seed));
      chk(ack, s);
      chk(sa, one(s, u));
      chk(sr, one(s && w && r == SUBSYSTEM_STATUS_REG, u));
      chk(led, |x);
      chk(done, 1);
      chk(srg, r);
      chk(swr, w);
    end
  endtask : traffic
  task automatic locked(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      {bus_init, xa} = 5'($random(seed));
      chk(ack, 0);
      chk(sa, 0);
      chk(sr, 4'hf);
      chk(led, 1);
      chk(failed, 1);
    end
  endtask : locked
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    rst = 0;
    wait_end(0);
    traffic(60);
    sw = 1;
    wait_end(0);
    sw = 0;
    traffic(20);
    {tf, sw} = 2'h3;
    wait_end(1);
    locked(10);
    // power cycle from the failed state must retest from scratch
    {tf, sw} = 2'h0;
    rst = 1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 0;
    wait_end(0);
    traffic(10);
    end_of_test();
  end
  initial begin
    #3000;
    n_errors++;
    end_of_test();
  end
endmodule : tb
